// file: cbam_cfg.svh
`ifndef CBAM_CFG_SVH
`define CBAM_CFG_SVH
// Register offset and field layout of the bank-select register
`define CBAM_BANKSEL_ADDR 8'h84
`define CBAM_BANKSEL_RESET 8'h00
`define CBAM_FETCH_LSB 0
`define CBAM_CONST_LSB 4
`define CBAM_WRITE_MASK 8'h33
// Address split and sizes
`define CBAM_BANK_ADDR_BITS 15
`define CBAM_UPPER_BIT 15
`define CBAM_LOCK_128K 17'h1FFFF
`define CBAM_LOCK_64K 17'h0FFFF
`define CBAM_LOCK_32K 17'h07FFF
`define CBAM_LOCK_16K 17'h03FFF
`define CBAM_RAM_LARGE 8448
`define CBAM_RAM_SMALL 4352
`define CBAM_IRAM_BYTES 256
`endif

// file: cbam_pkg.sv
package cbam_pkg;
    // Program memory variants
    typedef enum logic [1:0] {
        CBAM_V128K,
        CBAM_V64K,
        CBAM_V32K,
        CBAM_V16K
    } cbam_variant_type;
    // Target of a data-side access
    typedef enum logic [1:0] {
        CBAM_TGT_NONE,
        CBAM_TGT_FLASH,
        CBAM_TGT_AUXRAM
    } cbam_target_type;
endpackage

// file: cbam_bank_reg.sv
`timescale 1ns/100ps
`default_nettype none
`include "cbam_cfg.svh"
module cbam_bank_reg (
    input wire logic core_clk, // System clock
    input wire logic arst_n, // Async reset, active low
    input wire logic wr_en, // Register write strobe
    input wire logic [7:0] wr_data, // Write data
    input wire logic from_bank0, // Writing instruction runs in bank 0
    output logic [1:0] fetch_bank_field, // Fetch bank select
    output logic [1:0] constant_bank_field // Constant bank select
);
    import cbam_pkg::*;
    typedef struct packed {
        logic [1:0] fetch_r;
        logic [1:0] const_r;
    } cbam_breg_type;
    cbam_breg_type st_r;
    cbam_breg_type st_nxt;

    // Fetch field only moves when the writer sits in bank 0
    always_comb begin
        st_nxt = st_r;
        if (wr_en) begin
            st_nxt.const_r = wr_data[`CBAM_CONST_LSB +: 2];
            if (from_bank0) begin
                st_nxt.fetch_r = wr_data[`CBAM_FETCH_LSB +: 2];
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fetch_bank_field = st_r.fetch_r;
    assign constant_bank_field = st_r.const_r;
endmodule
`default_nettype wire

// file: cbam_addr_map.sv
`timescale 1ns/100ps
`default_nettype none
`include "cbam_cfg.svh"
module cbam_addr_map (
    input wire logic [15:0] logical_addr, // Core program address
    input wire logic [1:0] bank_field, // Applicable bank field
    input wire cbam_pkg::cbam_variant_type variant, // Memory variant
    output logic [16:0] phys_addr, // Physical flash address
    output logic is_lock, // Address is the lock byte
    output logic is_reserved // Address above the lock byte
);
    import cbam_pkg::*;
    logic [16:0] lock_addr;

    // Upper half takes the bank field, lower half is always bank 0
    always_comb begin
        if (logical_addr[`CBAM_UPPER_BIT]) begin
            phys_addr = {bank_field, logical_addr[`CBAM_BANK_ADDR_BITS-1:0]};
        end else begin
            phys_addr = {2'h0, logical_addr[`CBAM_BANK_ADDR_BITS-1:0]};
        end
    end

    // Lock byte is the last flash byte of each variant
    always_comb begin
        case (variant)
            CBAM_V128K: lock_addr = `CBAM_LOCK_128K;
            CBAM_V64K: lock_addr = `CBAM_LOCK_64K;
            CBAM_V32K: lock_addr = `CBAM_LOCK_32K;
            default: lock_addr = `CBAM_LOCK_16K;
        endcase
    end

    assign is_lock = (phys_addr == lock_addr);
    assign is_reserved = (phys_addr > lock_addr);
endmodule
`default_nettype wire

// file: cbam_mapper.sv
// How it works
// - Bank zero always sits at 0x0000 to 0x7FFF regardless of selection.
// - The largest variant has four equal 32 kB flash banks.
// - Two-bit fetch field picks the bank for upper-half instruction fetches.
// - Separate two-bit constant field picks bank for upper-half reads and flash writes.
// - Fetch field changes only from writes by code running in bank 0.
// - Reserved bank register bits read zero; software writes zeros there.
// - Last flash byte is the lock byte; anything above is reserved.
// - Code reads always use flash; move writes may program flash when enabled.
// - Move reads and writes go to auxiliary RAM by default.
// - Instruction type, not address, selects program or data space.
// - Data RAM is 8448 or 4352 bytes, 256 of them internal.
`timescale 1ns/100ps
`default_nettype none
`include "cbam_cfg.svh"
module cbam_mapper #(
    parameter cbam_pkg::cbam_variant_type VARIANT = cbam_pkg::CBAM_V128K
) (
    input wire logic core_clk, // System clock, 250 MHz
    input wire logic arst_n, // Async reset, active low
    input wire logic sfr_wr, // Register write strobe
    input wire logic sfr_rd, // Register read strobe
    input wire logic [7:0] sfr_addr, // Register address
    input wire logic [7:0] sfr_wdata, // Register write data
    input wire logic [15:0] exec_pc, // Address of executing instruction
    input wire logic fetch_req, // Instruction fetch request
    input wire logic [15:0] fetch_addr, // Fetch address
    input wire logic code_read_instruction, // Constant read request
    input wire logic external_move_instruction, // Move access request
    input wire logic xmove_write, // Move access is a write
    input wire logic [15:0] data_addr, // Constant or move address
    input wire logic flash_write_en, // Move writes reconfigured to flash
    output logic [7:0] sfr_rdata, // Register read data
    output logic fetch_valid, // Fetch address valid
    output logic [16:0] fetch_phys, // Physical fetch address
    output logic fetch_lock, // Fetch hits lock byte
    output logic fetch_rsvd, // Fetch above lock byte
    output logic data_valid, // Data-side access valid
    output cbam_pkg::cbam_target_type data_target, // Flash or auxiliary RAM
    output logic data_write, // Data access is a write
    output logic [16:0] data_phys, // Physical data address
    output logic data_lock, // Data hits lock byte
    output logic data_rsvd // Data above lock byte
);
    import cbam_pkg::*;

    typedef struct packed {
        logic [7:0] rdata;
        logic fvalid;
        logic [16:0] fphys;
        logic flock;
        logic frsvd;
        logic dvalid;
        cbam_target_type dtgt;
        logic dwrite;
        logic [16:0] dphys;
        logic dlock;
        logic drsvd;
    } cbam_state_type;

    cbam_state_type st_r;
    cbam_state_type st_nxt;
    logic [1:0] fetch_bank_field;
    logic [1:0] constant_bank_field;
    logic reg_hit;
    logic pc_in_bank0;
    logic [16:0] f_phys;
    logic f_lock;
    logic f_rsvd;
    logic [16:0] d_phys;
    logic d_lock;
    logic d_rsvd;
    logic [1:0] data_bank_sel;

    // Register decode; bank 0 holds the whole lower half
    always_comb begin
        if (sfr_addr == `CBAM_BANKSEL_ADDR) begin
            reg_hit = 1'b1;
        end else begin
            reg_hit = 1'b0;
        end
    end
    assign pc_in_bank0 = ~exec_pc[`CBAM_UPPER_BIT] | (fetch_bank_field == 2'h0);

    // Field values above the part's bank count are software's duty, not clamped
    cbam_bank_reg u_bank_reg (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .wr_en(sfr_wr & reg_hit),
        .wr_data(sfr_wdata & `CBAM_WRITE_MASK),
        .from_bank0(pc_in_bank0),
        .fetch_bank_field(fetch_bank_field),
        .constant_bank_field(constant_bank_field)
    );

    cbam_addr_map u_fetch_map (
        .logical_addr(fetch_addr),
        .bank_field(fetch_bank_field),
        .variant(VARIANT),
        .phys_addr(f_phys),
        .is_lock(f_lock),
        .is_reserved(f_rsvd)
    );

    assign data_bank_sel = constant_bank_field;

    cbam_addr_map u_data_map (
        .logical_addr(data_addr),
        .bank_field(data_bank_sel),
        .variant(VARIANT),
        .phys_addr(d_phys),
        .is_lock(d_lock),
        .is_reserved(d_rsvd)
    );

    // Next state: register read data and routed access, one cycle late
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;
        if (sfr_rd && reg_hit) begin
            // Reserved pairs read back as zero
            st_nxt.rdata = {2'h0, constant_bank_field, 2'h0, fetch_bank_field};
        end
        st_nxt.fvalid = fetch_req;
        st_nxt.fphys = fetch_req ? f_phys : st_r.fphys;
        st_nxt.flock = fetch_req & f_lock;
        st_nxt.frsvd = fetch_req & f_rsvd;
        // Instruction type decides the space, never the address
        st_nxt.dvalid = 1'b0;
        st_nxt.dtgt = CBAM_TGT_NONE;
        st_nxt.dwrite = 1'b0;
        st_nxt.dlock = 1'b0;
        st_nxt.drsvd = 1'b0;
        if (code_read_instruction) begin
            st_nxt.dvalid = 1'b1;
            st_nxt.dtgt = CBAM_TGT_FLASH;
            st_nxt.dphys = d_phys;
            st_nxt.dlock = d_lock;
            st_nxt.drsvd = d_rsvd;
        end else if (external_move_instruction) begin
            st_nxt.dvalid = 1'b1;
            st_nxt.dwrite = xmove_write;
            if (flash_write_en && xmove_write) begin
                st_nxt.dtgt = CBAM_TGT_FLASH;
                st_nxt.dphys = d_phys;
                st_nxt.dlock = d_lock;
                st_nxt.drsvd = d_rsvd;
            end else begin
                // Auxiliary RAM sees the raw 16-bit address
                st_nxt.dtgt = CBAM_TGT_AUXRAM;
                st_nxt.dphys = {1'b0, data_addr};
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sfr_rdata = st_r.rdata;
    assign fetch_valid = st_r.fvalid;
    assign fetch_phys = st_r.fphys;
    assign fetch_lock = st_r.flock;
    assign fetch_rsvd = st_r.frsvd;
    assign data_valid = st_r.dvalid;
    assign data_target = st_r.dtgt;
    assign data_write = st_r.dwrite;
    assign data_phys = st_r.dphys;
    assign data_lock = st_r.dlock;
    assign data_rsvd = st_r.drsvd;
endmodule
`default_nettype wire

// file: cbam_mapper_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module cbam_mapper_monitor (
    input wire logic core_clk, // Clock
    input wire logic arst_n, // Reset
    input wire logic [7:0] sfr_rdata, // Read data
    input wire logic fetch_req, // Fetch strobe
    input wire logic [15:0] fetch_addr, // Fetch address
    input wire logic fetch_valid, // Fetch answer
    input wire logic [16:0] fetch_phys, // Fetch phys
    input wire logic fetch_lock, // Lock hit
    input wire logic fetch_rsvd, // Reserved hit
    input wire logic code_read_instruction, // Const read
    input wire logic external_move_instruction, // Move
    input wire logic flash_write_en, // Move writes to flash
    input wire logic [15:0] data_addr, // Data address
    input wire logic data_valid, // Data answer
    input wire cbam_pkg::cbam_target_type data_target, // Target
    input wire logic [16:0] data_phys // Data phys
);
    import cbam_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    // Lower-half constant reads must never leave bank zero
    sequence s_const_low;
        code_read_instruction && !data_addr[15];
    endsequence
    sequence s_plain_move;
        external_move_instruction && !code_read_instruction && !flash_write_en;
    endsequence
    // Answers land exactly one edge after the request
    a_fetch_answer: assert property (fetch_req |=> fetch_valid)
        else $error("fetch answer missing");
    a_fetch_low_bank: assert property (fetch_req && !fetch_addr[15] |=>
        fetch_phys == {2'b00, $past(fetch_addr[14:0])}) else $error("low fetch left bank 0");
    a_fetch_offset: assert property (fetch_req |=>
        fetch_phys[14:0] == $past(fetch_addr[14:0])) else $error("fetch offset wrong");
    a_fetch_lock: assert property (fetch_valid |->
        fetch_lock == (fetch_phys == 17'h1FFFF) && !fetch_rsvd) else $error("lock flag wrong");
    a_const_flash: assert property (code_read_instruction |=>
        data_valid && data_target == CBAM_TGT_FLASH) else $error("const read not flash");
    a_move_auxram: assert property (s_plain_move |=>
        data_target == CBAM_TGT_AUXRAM) else $error("move not aux ram");
    a_const_low: assert property (s_const_low |=> data_phys[16:15] == 2'b00)
        else $error("low const left bank 0");
    a_rsvd_zero: assert property (sfr_rdata[7:6] == 2'b00 && sfr_rdata[3:2] == 2'b00)
        else $error("reserved bits set");
endmodule
bind cbam_mapper cbam_mapper_monitor u_cbam_mapper_monitor (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sfr_rdata(sfr_rdata),
    .fetch_req(fetch_req),
    .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid),
    .fetch_phys(fetch_phys),
    .fetch_lock(fetch_lock),
    .fetch_rsvd(fetch_rsvd),
    .code_read_instruction(code_read_instruction),
    .external_move_instruction(external_move_instruction),
    .flash_write_en(flash_write_en),
    .data_addr(data_addr),
    .data_valid(data_valid),
    .data_target(data_target),
    .data_phys(data_phys)
);
`default_nettype wire

// file: cbam_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module cbam_core_model (
    input wire logic core_clk, // Clock
    output var logic fetch_req, // Fetch strobe
    output var logic [15:0] fetch_addr, // Fetch address
    output var logic code_read_instruction, // Const read
    output var logic external_move_instruction, // Move
    output var logic xmove_write, // Move is write
    output var logic [15:0] data_addr, // Data address
    output var logic flash_write_en // Move writes to flash
);
    // Idle core at time zero
    initial begin
        fetch_req = 1'b0;
        fetch_addr = 16'h0000;
        code_read_instruction = 1'b0;
        external_move_instruction = 1'b0;
        xmove_write = 1'b0;
        data_addr = 16'h0000;
        flash_write_en = 1'b0;
    end
    // Held one edge; released address inverted so stale values never match
    task automatic fetch(input logic [15:0] a);
        @(negedge core_clk);
        fetch_req = 1'b1;
        fetch_addr = a;
        @(negedge core_clk);
        fetch_req = 1'b0;
        fetch_addr = ~a;
    endtask
    // Flash redirect is a level and stays as last set
    task automatic data(input logic c, input logic m, input logic w, input logic f,
        input logic [15:0] a);
        @(negedge core_clk);
        code_read_instruction = c;
        external_move_instruction = m;
        xmove_write = w;
        flash_write_en = f;
        data_addr = a;
        @(negedge core_clk);
        code_read_instruction = 1'b0;
        external_move_instruction = 1'b0;
        xmove_write = ~w;
        data_addr = ~a;
    endtask
endmodule
`default_nettype wire

// file: cbam_mapper_bench.sv
`timescale 1ns/100ps
`default_nettype none
module cbam_mapper_bench;
    import cbam_pkg::*;
    logic core_clk, arst_n, sfr_wr, sfr_rd, fetch_req, code_read_instruction, xmove_write;
    logic external_move_instruction, flash_write_en, fetch_valid, fetch_lock, fetch_rsvd;
    logic data_valid, data_write, data_lock, data_rsvd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [15:0] exec_pc, fetch_addr, data_addr;
    logic [16:0] fetch_phys, data_phys;
    cbam_target_type data_target;
    int errors;
    int tests_run;
    // Largest variant, so every bank code is legal for software
    cbam_mapper #(.VARIANT(CBAM_V128K)) u_cbam_mapper (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata),
        .exec_pc(exec_pc),
        .fetch_req(fetch_req),
        .fetch_addr(fetch_addr),
        .code_read_instruction(code_read_instruction),
        .external_move_instruction(external_move_instruction),
        .xmove_write(xmove_write),
        .data_addr(data_addr),
        .flash_write_en(flash_write_en),
        .sfr_rdata(sfr_rdata),
        .fetch_valid(fetch_valid),
        .fetch_phys(fetch_phys),
        .fetch_lock(fetch_lock),
        .fetch_rsvd(fetch_rsvd),
        .data_valid(data_valid),
        .data_target(data_target),
        .data_write(data_write),
        .data_phys(data_phys),
        .data_lock(data_lock),
        .data_rsvd(data_rsvd)
    );
    cbam_core_model u_cbam_core_model (
        .core_clk(core_clk),
        .fetch_req(fetch_req),
        .fetch_addr(fetch_addr),
        .code_read_instruction(code_read_instruction),
        .external_move_instruction(external_move_instruction),
        .xmove_write(xmove_write),
        .data_addr(data_addr),
        .flash_write_en(flash_write_en)
    );
    // Clock of 4 ns
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Watchdog, far beyond the fewer than a hundred cycles of the run
    initial begin
        #40000;
        errors++;
        end_sim();
    end
    task automatic chk(input logic [16:0] s, input logic [16:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] d, input logic [15:0] pc);
        @(negedge core_clk);
        sfr_wr = 1'b1;
        sfr_addr = 8'h84;
        sfr_wdata = d;
        exec_pc = pc;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        sfr_rd = 1'b1;
        sfr_addr = a;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        chk({9'h000, sfr_rdata}, {9'h000, e});
    endtask
    task automatic end_sim();
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        errors = 0;
        tests_run = 0;
        arst_n = 1'b0;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        exec_pc = 16'h0000;
        repeat (20) @(negedge core_clk);
        arst_n = 1'b1;
        rd(8'h84, 8'h00);
        wr(8'hFF, 16'h1000);
        rd(8'h84, 8'h33);
        rd(8'h85, 8'h00);
        for (int f = 0; f < 4; f++) begin
            wr({2'b00, f[1:0], 2'b00, f[1:0]}, 16'h0100);
            u_cbam_core_model.fetch(16'h8004);
            chk(fetch_phys, {f[1:0], 15'h0004});
            u_cbam_core_model.fetch(16'h0004);
            chk(fetch_phys, 17'h00004);
            u_cbam_core_model.data(1'b1, 1'b0, 1'b0, 1'b0, 16'hC000);
            chk(data_phys, {f[1:0], 15'h4000});
        end
        u_cbam_core_model.fetch(16'hFFFF);
        chk({15'h0000, fetch_lock, fetch_rsvd}, 17'h00002);
        u_cbam_core_model.fetch(16'hFFFE);
        chk({16'h0000, fetch_lock}, 17'h00000);
        // Fetch field frozen for writers outside bank zero
        wr(8'h01, 16'h0100);
        wr(8'h22, 16'h9000);
        rd(8'h84, 8'h21);
        u_cbam_core_model.data(1'b0, 1'b1, 1'b0, 1'b0, 16'h1234);
        chk(data_phys, 17'h01234);
        chk({15'h0000, data_target}, {15'h0000, CBAM_TGT_AUXRAM});
        u_cbam_core_model.data(1'b0, 1'b1, 1'b1, 1'b1, 16'h8010);
        chk(data_phys, 17'h10010);
        chk({16'h0000, data_write}, 17'h00001);
        u_cbam_core_model.data(1'b1, 1'b1, 1'b0, 1'b1, 16'h0040);
        chk({15'h0000, data_target}, {15'h0000, CBAM_TGT_FLASH});
        // Constant read of the top of bank three hits the lock byte
        wr(8'h30, 16'h0100);
        u_cbam_core_model.data(1'b1, 1'b0, 1'b0, 1'b0, 16'hFFFF);
        chk({15'h0000, data_lock, data_rsvd}, 17'h00002);
        chk({16'h0000, data_write}, 17'h00000);
        // Reset in mid-run returns the register to zero
        @(negedge core_clk);
        arst_n = 1'b0;
        @(negedge core_clk);
        arst_n = 1'b1;
        rd(8'h84, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
